// file: core/iit_pkg.sv
// package: instruction classes, decoded-instruction carrier, interlock counts
`default_nettype none
package iit_pkg;
  typedef enum logic [4:0] {
    CLS_OTHER,
    CLS_IDLE,
    CLS_SYSCP_MOVE_TO,
    CLS_TLB_OP,
    CLS_CACHE_OP,
    CLS_JUMP,
    CLS_BRANCH,
    CLS_BRANCH_LIKELY,
    CLS_MUL_HILO,
    CLS_MUL_REG,
    CLS_DIVIDE,
    CLS_MOVE_FROM_HILO,
    CLS_MOVE_TO_HILO,
    CLS_SYSCP_MOVE_FROM,
    CLS_LOAD,
    CLS_MEDIA_MUL,
    CLS_MEDIA_ACC,
    CLS_MEDIA_LOAD,
    CLS_INT_TO_MEDIA,
    CLS_MEDIA_TO_INT,
    CLS_MEDIA_OTHER
  } iit_class_type;

  // one decoded instruction offered for issue
  typedef struct packed {
    iit_class_type cls;
    logic [4:0] dst;
    logic dstValid;
    logic [4:0] srcA;
    logic [4:0] srcB;
    logic srcAValid;
    logic srcBValid;
    logic mediaDst;
    logic mediaSrc;
  } iit_instr_type;

  // branch resolution reported while the instruction after the branch is offered
  typedef struct packed {
    logic valid;
    logic btbHit;
    logic predTaken;
    logic taken;
  } iit_branch_type;

  localparam logic [5:0] SYSCP_EXTRA = 6'h03;
  localparam logic [5:0] CACHE_EXTRA = 6'h01;
  localparam logic [5:0] BRANCH_MISS_EXTRA = 6'h03;
  localparam logic [5:0] LIKELY_MISS_TAKEN_EXTRA = 6'h03;
  localparam logic [5:0] LIKELY_MISS_UNTAKEN_EXTRA = 6'h01;
  localparam logic [5:0] LIKELY_PRED_T_UNTAKEN_EXTRA = 6'h04;
  localparam logic [5:0] LIKELY_PRED_U_TAKEN_EXTRA = 6'h03;
  localparam logic [5:0] MDU_EXTRA = 6'h03;
  localparam logic [5:0] RAW_EXTRA = 6'h03;
  localparam logic [5:0] MEDIA_MUL_EXTRA = 6'h02;
  localparam logic [5:0] MEDIA_SHORT_EXTRA = 6'h01;
  localparam logic [5:0] DIV_MIN_EXTRA = 6'h03;
  localparam logic [5:0] DIV_MAX_EXTRA = 6'h22;
  localparam logic [5:0] DIV_HILO_MIN = 6'h01;
  localparam logic [5:0] DIV_HILO_MAX = 6'h21;
  localparam logic [31:0] PROC_ID_RESET = 32'h00c0ffee; // arbitrary value
endpackage
`default_nettype wire

// file: core/iit_div_timer.sv
// divide busy timer: counts the operand-dependent divide latency down
`default_nettype none
module iit_div_timer #(
  parameter int WIDTH = 6
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic clkEn,
  input wire logic start,
  input wire logic [WIDTH-1:0] length,
  output logic [WIDTH-1:0] remain
);
  typedef struct packed {
    logic [WIDTH-1:0] cnt;
  } iit_dstate_type;
  iit_dstate_type st;
  iit_dstate_type next_st;

  always_comb begin
    next_st = st;
    if (start) begin
      next_st.cnt = length;
    end else if (st.cnt != '0) begin
      next_st.cnt = st.cnt - WIDTH'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      st <= '0;
    end else if (clkEn) begin
      st <= next_st;
    end
  end

  assign remain = st.cnt;
endmodule
`default_nettype wire

// file: core/iit_issue_interlock.sv
// issue interlock: decides how long each offered instruction waits before issue
// Summary of operation
// RL1: with no hazard one instruction issues every cycle; unlisted pairs add no extra cycle
// RL2: idle instruction holds issue of followers until an interrupt arrives
// RL3: system coprocessor write or tlb op stalls next by 3; cache op by 1
// RL4: jump or branch: no penalty if prediction right or miss-untaken, else 3
// RL5: likely branch penalties 0,3,1,4,3 by prediction and outcome case
// RL6: after a hilo or reg multiply, next multiply-divide or hilo move waits 3 extra
// RL7: after accumulate or divide, unrelated non-multiply-divide ops issue freely
// RL8: reading result of reg multiply, moves-from, load or media-to-int waits 3
// RL9: after divide, next multiply, accumulate or divide waits 3 to 34
// RL10: after divide, a move from high or low waits 1 to 33
// RL11: after dual half multiply, dependent media instruction waits 2 extra
// RL12: after media accumulate, abs-diff sum or max/min, dependent media waits 1
// RL13: after media load or int-to-media move, dependent media waits 1
// RL14: processor id read returns a fixed 32-bit value
// RL15: stalls hold the instruction and insert bubbles; order and results unchanged
`default_nettype none
module iit_issue_interlock #(
  parameter logic [31:0] PROC_ID = iit_pkg::PROC_ID_RESET
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic clkEn,
  input wire logic offerValid,
  input wire iit_pkg::iit_instr_type offer,
  input wire iit_pkg::iit_branch_type branchRes,
  input wire logic [5:0] divLength,
  input wire logic irqPending,
  input wire logic procIdRead,
  output logic issue,
  output logic bubble,
  output logic idleWait,
  output logic [5:0] stallLeft,
  output logic [31:0] procIdData,
  output logic procIdValid
);
  typedef enum logic [1:0] {
    RUN,
    STALL,
    IDLE
  } iit_mode_type;

  typedef struct packed {
    iit_mode_type mode;
    logic [5:0] cnt;
    iit_pkg::iit_instr_type last;
    logic lastValid;
    logic mulBusy;
    logic issue;
    logic bubble;
    logic [31:0] idData;
    logic idValid;
    logic idle;
  } iit_state_type;

  iit_state_type st;
  iit_state_type next_st;
  logic [5:0] divRemain;
  logic divStart;
  logic [5:0] hazard;
  logic [5:0] branchPen;
  logic raw;
  logic mediaRaw;
  logic offerMdu;
  logic offerHilo;
  logic [5:0] divHiloWait;
  logic [5:0] divMulWait;

  iit_div_timer #(
    .WIDTH(6)
  ) iit_div_timer_inst (
    .mclk(mclk),
    .rstn(rstn),
    .clkEn(clkEn),
    .start(divStart),
    .length(divLength),
    .remain(divRemain)
  );

  always_comb begin
    raw = st.lastValid && st.last.dstValid && !st.last.mediaDst &&
        ((offer.srcAValid && offer.srcA == st.last.dst) ||
         (offer.srcBValid && offer.srcB == st.last.dst));
    mediaRaw = st.lastValid && st.last.dstValid && st.last.mediaDst && offer.mediaSrc &&
        ((offer.srcAValid && offer.srcA == st.last.dst) ||
         (offer.srcBValid && offer.srcB == st.last.dst));
    offerMdu = offer.cls inside {iit_pkg::CLS_MUL_HILO, iit_pkg::CLS_MUL_REG,
        iit_pkg::CLS_DIVIDE};
    offerHilo = offer.cls inside {iit_pkg::CLS_MOVE_FROM_HILO, iit_pkg::CLS_MOVE_TO_HILO};
    hazard = '0;
    if (st.lastValid) begin
      case (st.last.cls)
        iit_pkg::CLS_SYSCP_MOVE_TO,
        iit_pkg::CLS_TLB_OP: hazard = iit_pkg::SYSCP_EXTRA; // RL3
        iit_pkg::CLS_CACHE_OP: hazard = iit_pkg::CACHE_EXTRA; // RL3
        iit_pkg::CLS_MUL_HILO: begin
          if (offerMdu || offerHilo) begin
            hazard = iit_pkg::MDU_EXTRA; // RL6
          end
        end
        iit_pkg::CLS_MUL_REG: begin
          if (offerMdu || offerHilo) begin
            hazard = iit_pkg::MDU_EXTRA; // RL6
          end else if (raw) begin
            hazard = iit_pkg::RAW_EXTRA; // RL8
          end
        end
        iit_pkg::CLS_MOVE_FROM_HILO,
        iit_pkg::CLS_SYSCP_MOVE_FROM,
        iit_pkg::CLS_LOAD,
        iit_pkg::CLS_MEDIA_TO_INT: begin
          if (raw) begin
            hazard = iit_pkg::RAW_EXTRA; // RL8
          end
        end
        iit_pkg::CLS_MEDIA_MUL: begin
          if (mediaRaw) begin
            hazard = iit_pkg::MEDIA_MUL_EXTRA; // RL11
          end
        end
        iit_pkg::CLS_MEDIA_ACC,
        iit_pkg::CLS_MEDIA_LOAD,
        iit_pkg::CLS_INT_TO_MEDIA: begin
          if (mediaRaw) begin
            hazard = iit_pkg::MEDIA_SHORT_EXTRA; // RL12 RL13
          end
        end
        default: hazard = '0; // RL1 RL7
      endcase
    end
    // divide latency is tracked by the timer, not only the previous instruction
    // waits held inside their allowed span for any nonzero loaded length
    divHiloWait = (divRemain > iit_pkg::DIV_HILO_MAX) ? iit_pkg::DIV_HILO_MAX : divRemain;
    divMulWait = divHiloWait + iit_pkg::DIV_MIN_EXTRA - iit_pkg::DIV_HILO_MIN;
    if (divMulWait > iit_pkg::DIV_MAX_EXTRA) begin
      divMulWait = iit_pkg::DIV_MAX_EXTRA; // RL9
    end
    if (divRemain != '0 && (offerMdu || offer.cls == iit_pkg::CLS_MOVE_FROM_HILO)) begin
      if (offer.cls == iit_pkg::CLS_MOVE_FROM_HILO) begin
        if (divHiloWait > hazard) begin
          hazard = divHiloWait; // RL10
        end
      end else if (divMulWait > hazard) begin
        hazard = divMulWait; // RL9
      end
    end
    branchPen = '0;
    if (branchRes.valid && st.lastValid) begin
      if (st.last.cls == iit_pkg::CLS_BRANCH_LIKELY) begin
        if (!branchRes.btbHit) begin
          branchPen = branchRes.taken ? iit_pkg::LIKELY_MISS_TAKEN_EXTRA :
              iit_pkg::LIKELY_MISS_UNTAKEN_EXTRA; // RL5
        end else if (branchRes.predTaken && !branchRes.taken) begin
          branchPen = iit_pkg::LIKELY_PRED_T_UNTAKEN_EXTRA; // RL5
        end else if (!branchRes.predTaken && branchRes.taken) begin
          branchPen = iit_pkg::LIKELY_PRED_U_TAKEN_EXTRA; // RL5
        end
      end else if (st.last.cls inside {iit_pkg::CLS_JUMP, iit_pkg::CLS_BRANCH}) begin
        if (branchRes.btbHit ? (branchRes.predTaken != branchRes.taken) : branchRes.taken) begin
          branchPen = iit_pkg::BRANCH_MISS_EXTRA; // RL4
        end
      end
    end
    if (branchPen > hazard) begin
      hazard = branchPen;
    end
  end

  always_comb begin
    next_st = st;
    next_st.issue = 1'b0;
    next_st.bubble = 1'b0;
    next_st.idValid = procIdRead;
    next_st.idData = procIdRead ? PROC_ID : 32'h00000000; // RL14
    divStart = 1'b0;
    case (st.mode)
      RUN: begin
        if (offerValid) begin
          if (hazard != '0) begin
            next_st.mode = STALL; // RL15
            next_st.cnt = hazard - 6'h01;
            next_st.bubble = 1'b1;
            next_st.lastValid = 1'b0;
          end else begin
            next_st.issue = 1'b1; // RL1
            next_st.last = offer;
            next_st.lastValid = 1'b1;
            divStart = offer.cls == iit_pkg::CLS_DIVIDE;
            if (offer.cls == iit_pkg::CLS_IDLE && !irqPending) begin
              next_st.mode = IDLE; // RL2
            end
          end
        end else begin
          next_st.lastValid = 1'b0;
        end
      end
      STALL: begin
        if (st.cnt == '0) begin
          next_st.mode = RUN;
          next_st.issue = offerValid; // RL15
          if (offerValid) begin
            next_st.last = offer;
            next_st.lastValid = 1'b1;
            divStart = offer.cls == iit_pkg::CLS_DIVIDE;
            if (offer.cls == iit_pkg::CLS_IDLE && !irqPending) begin
              next_st.mode = IDLE; // RL2
            end
          end
        end else begin
          next_st.cnt = st.cnt - 6'h01;
          next_st.bubble = 1'b1; // RL15
        end
      end
      IDLE: begin
        next_st.bubble = 1'b1; // RL2
        next_st.lastValid = 1'b0;
        if (irqPending) begin
          next_st.mode = RUN;
        end
      end
      default: next_st.mode = RUN;
    endcase
    next_st.idle = next_st.mode == IDLE;
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      st <= '0;
    end else if (clkEn) begin
      st <= next_st;
    end
  end

  assign issue = st.issue;
  assign bubble = st.bubble;
  assign idleWait = st.idle;
  assign stallLeft = st.cnt;
  assign procIdData = st.idData;
  assign procIdValid = st.idValid;

  property p_idle_holds;
    @(posedge mclk) disable iff (!rstn)
    (st.mode == IDLE && !irqPending && clkEn) |=> !issue;
  endproperty
  a_idle_holds: assert property (p_idle_holds) else $error("issue during idle"); // RL2

  property p_id_value;
    @(posedge mclk) disable iff (!rstn)
    (procIdRead && clkEn) |=> (procIdValid && procIdData == PROC_ID);
  endproperty
  a_id_value: assert property (p_id_value) else $error("wrong processor id"); // RL14

  property p_no_both;
    @(posedge mclk) disable iff (!rstn)
    !(issue && bubble);
  endproperty
  a_no_both: assert property (p_no_both) else $error("issue and bubble together"); // RL15

  property p_free_issue;
    @(posedge mclk) disable iff (!rstn)
    (st.mode == RUN && offerValid && hazard == '0 && clkEn) |=> issue;
  endproperty
  a_free_issue: assert property (p_free_issue) else $error("no issue without hazard"); // RL1

  property p_syscp_stall;
    @(posedge mclk) disable iff (!rstn)
    (st.mode == RUN && offerValid && st.lastValid && clkEn && hazard == 6'h03 &&
        st.last.cls == iit_pkg::CLS_SYSCP_MOVE_TO) ##1 clkEn [*3] |=> issue;
  endproperty
  a_syscp_stall: assert property (p_syscp_stall) else $error("syscp stall length"); // RL3

  property p_cache_stall;
    @(posedge mclk) disable iff (!rstn)
    (st.mode == RUN && offerValid && st.lastValid && clkEn &&
        st.last.cls == iit_pkg::CLS_CACHE_OP && hazard == 6'h01) |=> bubble;
  endproperty
  a_cache_stall: assert property (p_cache_stall) else $error("cache stall missing"); // RL3

  property p_stall_count;
    @(posedge mclk) disable iff (!rstn)
    (st.mode == STALL && st.cnt != '0 && clkEn) |=> (st.cnt == $past(st.cnt) - 6'h01);
  endproperty
  a_stall_count: assert property (p_stall_count) else $error("stall count slip"); // RL15

  property p_mdu_hazard;
    @(posedge mclk) disable iff (!rstn)
    (st.lastValid && st.last.cls == iit_pkg::CLS_MUL_HILO && (offerMdu || offerHilo))
        |-> hazard >= iit_pkg::MDU_EXTRA;
  endproperty
  a_mdu_hazard: assert property (p_mdu_hazard) else $error("multiply hazard missed"); // RL6

  property p_branch_pen;
    @(posedge mclk) disable iff (!rstn)
    (st.mode == RUN && offerValid && clkEn && st.lastValid && branchRes.valid &&
        st.last.cls inside {iit_pkg::CLS_JUMP, iit_pkg::CLS_BRANCH} && branchRes.btbHit &&
        branchRes.predTaken != branchRes.taken)
        |=> (bubble && stallLeft >= iit_pkg::BRANCH_MISS_EXTRA - 6'h01);
  endproperty
  a_branch_pen: assert property (p_branch_pen) else $error("branch penalty missing"); // RL4

  property p_likely_pen;
    @(posedge mclk) disable iff (!rstn)
    (st.mode == RUN && offerValid && clkEn && st.lastValid && branchRes.valid &&
        st.last.cls == iit_pkg::CLS_BRANCH_LIKELY && branchRes.btbHit &&
        branchRes.predTaken && !branchRes.taken)
        |=> (bubble && stallLeft >= iit_pkg::LIKELY_PRED_T_UNTAKEN_EXTRA - 6'h01);
  endproperty
  a_likely_pen: assert property (p_likely_pen) else $error("likely penalty missing"); // RL5

  property p_load_raw;
    @(posedge mclk) disable iff (!rstn)
    (st.mode == RUN && offerValid && clkEn && raw && st.last.cls == iit_pkg::CLS_LOAD)
        |=> (bubble && stallLeft >= iit_pkg::RAW_EXTRA - 6'h01);
  endproperty
  a_load_raw: assert property (p_load_raw) else $error("load dependency missed"); // RL8

  property p_div_bound;
    @(posedge mclk) disable iff (!rstn)
    (st.mode == STALL) |-> (st.cnt < iit_pkg::DIV_MAX_EXTRA);
  endproperty
  a_div_bound: assert property (p_div_bound) else $error("stall beyond divide ceiling"); // RL9

  c_stall: cover property (@(posedge mclk) disable iff (!rstn) st.mode == STALL ##1 issue);
  c_idle: cover property (@(posedge mclk) disable iff (!rstn) idleWait ##1 !idleWait);
  c_div: cover property (@(posedge mclk) disable iff (!rstn) divRemain == 6'h05);
endmodule
`default_nettype wire

// file: tb/iit_issue_interlock_tb.sv
// self-checking bench for the issue interlock block
`default_nettype none
module iit_issue_interlock_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [31:0] ID = 32'h5a5a0001; // arbitrary value
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic clkEn = 1'b1;
  logic offerValid = 1'b0;
  iit_pkg::iit_instr_type offer = '0;
  iit_pkg::iit_branch_type branchRes = '0;
  logic [5:0] divLength = 6'h01;
  logic irqPending = 1'b0;
  logic procIdRead = 1'b0;
  logic issue, bubble, idleWait, procIdValid;
  logic [5:0] stallLeft;
  logic [31:0] procIdData;
  int fails = 0;
  int compares = 0;
  int cycles = 0;
  int n;
  int b;
  int s;
  iit_issue_interlock #(.PROC_ID(ID)) iit_issue_interlock_inst (.mclk(mclk), .rstn(rstn),
    .clkEn(clkEn), .offerValid(offerValid), .offer(offer), .branchRes(branchRes),
    .divLength(divLength), .irqPending(irqPending), .procIdRead(procIdRead), .issue(issue),
    .bubble(bubble), .idleWait(idleWait), .stallLeft(stallLeft), .procIdData(procIdData),
    .procIdValid(procIdValid));
  always #2.5 mclk = ~mclk;
  task stop_test;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      fails = fails + 1;
      stop_test();
    end
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    compares = compares + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic iit_pkg::iit_instr_type ins(iit_pkg::iit_class_type c, logic [4:0] s,
                                                 logic m);
    ins = '{c, 5'h01, 1'b1, s, 5'h00, 1'b1, 1'b0, m, m};
  endfunction
  // issue a then b; n counts cycles from a issued to b issued, b the bubbles between
  task pair(input iit_pkg::iit_instr_type a, input iit_pkg::iit_instr_type bi,
            input iit_pkg::iit_branch_type br, input int ext);
    repeat (40) @(negedge mclk);
    offer = a;
    offerValid = 1'b1;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (issue !== 1'b1 && n < 60);
    offer = bi;
    branchRes = br;
    n = 0;
    b = 0;
    do begin
      @(negedge mclk);
      n++;
      if (bubble === 1'b1) b++;
      if (n == 1) s = stallLeft;
    end while (issue !== 1'b1 && n < 60);
    offerValid = 1'b0;
    branchRes = '0;
    if (ext >= 0) begin
      check(32'(n), 32'(ext + 1));
      check(32'(b), 32'(ext));
      check(32'(s), 32'((ext > 0) ? ext - 1 : 0));
    end
  endtask
  task t_plain;
    pair(ins(iit_pkg::CLS_OTHER, 5'h02, 1'b0), ins(iit_pkg::CLS_OTHER, 5'h02, 1'b0), '0, 0);
    pair(ins(iit_pkg::CLS_CACHE_OP, 5'h02, 1'b0), ins(iit_pkg::CLS_OTHER, 5'h02, 1'b0), '0, 1);
    pair(ins(iit_pkg::CLS_SYSCP_MOVE_TO, 5'h02, 1'b0), ins(iit_pkg::CLS_OTHER, 5'h02, 1'b0),
         '0, 3);
    pair(ins(iit_pkg::CLS_TLB_OP, 5'h02, 1'b0), ins(iit_pkg::CLS_OTHER, 5'h02, 1'b0), '0, 3);
    $display("test plain done");
  endtask
  task t_branch;
    iit_pkg::iit_branch_type br;
    int e;
    for (int i = 0; i < 8; i++) begin
      br = '{1'b1, i[2], i[1], i[0]};
      e = (i[2] ? (i[1] == i[0]) : !i[0]) ? 0 : 3;
      pair(ins(iit_pkg::CLS_BRANCH, 5'h02, 1'b0), ins(iit_pkg::CLS_OTHER, 5'h02, 1'b0), br, e);
      pair(ins(iit_pkg::CLS_JUMP, 5'h02, 1'b0), ins(iit_pkg::CLS_OTHER, 5'h02, 1'b0), br, e);
      e = !i[2] ? (i[0] ? 3 : 1) : i[1] ? (i[0] ? 0 : 4) : 3;
      if (i[2] || i[1] || i[0]) begin
        if (!(i[2] && !i[1] && !i[0]))
          pair(ins(iit_pkg::CLS_BRANCH_LIKELY, 5'h02, 1'b0), ins(iit_pkg::CLS_OTHER, 5'h02, 1'b0),
               br, e);
      end
    end
    $display("test branch done");
  endtask
  task t_mdu;
    iit_pkg::iit_class_type f[5] = '{iit_pkg::CLS_MUL_HILO, iit_pkg::CLS_MUL_REG,
      iit_pkg::CLS_DIVIDE, iit_pkg::CLS_MOVE_FROM_HILO, iit_pkg::CLS_MOVE_TO_HILO};
    for (int i = 0; i < 5; i++) begin
      pair(ins(iit_pkg::CLS_MUL_HILO, 5'h02, 1'b0), ins(f[i], 5'h02, 1'b0), '0, 3);
      pair(ins(iit_pkg::CLS_MUL_REG, 5'h02, 1'b0), ins(f[i], 5'h02, 1'b0), '0, 3);
    end
    pair(ins(iit_pkg::CLS_MUL_HILO, 5'h02, 1'b0), ins(iit_pkg::CLS_OTHER, 5'h02, 1'b0), '0, 0);
    $display("test mdu done");
  endtask
  task t_raw;
    iit_pkg::iit_class_type f[5] = '{iit_pkg::CLS_LOAD, iit_pkg::CLS_MOVE_FROM_HILO,
      iit_pkg::CLS_SYSCP_MOVE_FROM, iit_pkg::CLS_MEDIA_TO_INT, iit_pkg::CLS_MUL_REG};
    for (int i = 0; i < 5; i++) begin
      pair(ins(f[i], 5'h02, 1'b0), ins(iit_pkg::CLS_OTHER, 5'h01, 1'b0), '0, 3);
      pair(ins(f[i], 5'h02, 1'b0), ins(iit_pkg::CLS_OTHER, 5'h02, 1'b0), '0, 0);
    end
    $display("test raw done");
  endtask
  task t_media;
    iit_pkg::iit_class_type f[4] = '{iit_pkg::CLS_MEDIA_MUL, iit_pkg::CLS_MEDIA_ACC,
      iit_pkg::CLS_MEDIA_LOAD, iit_pkg::CLS_INT_TO_MEDIA};
    for (int i = 0; i < 4; i++) begin
      pair(ins(f[i], 5'h02, 1'b1), ins(iit_pkg::CLS_MEDIA_OTHER, 5'h01, 1'b1), '0,
           (i == 0) ? 2 : 1);
      pair(ins(f[i], 5'h02, 1'b1), ins(iit_pkg::CLS_MEDIA_OTHER, 5'h02, 1'b1), '0, 0);
      pair(ins(f[i], 5'h02, 1'b1), ins(iit_pkg::CLS_OTHER, 5'h01, 1'b0), '0, 0);
    end
    $display("test media done");
  endtask
  task t_div;
    int lo;
    for (int i = 0; i < 2; i++) begin
      divLength = i ? 6'h21 : 6'h01;
      pair(ins(iit_pkg::CLS_DIVIDE, 5'h02, 1'b0), ins(iit_pkg::CLS_MUL_HILO, 5'h02, 1'b0), '0, -1);
      check(32'(n > 3 && n < 36), 32'h00000001);
      if (i) check(32'(n > lo), 32'h00000001);
      lo = n;
      pair(ins(iit_pkg::CLS_DIVIDE, 5'h02, 1'b0), ins(iit_pkg::CLS_MOVE_FROM_HILO, 5'h02, 1'b0),
           '0, -1);
      check(32'(n > 1 && n < 35), 32'h00000001);
      pair(ins(iit_pkg::CLS_DIVIDE, 5'h02, 1'b0), ins(iit_pkg::CLS_OTHER, 5'h02, 1'b0), '0, 0);
    end
    $display("test divide done");
  endtask
  task t_idle;
    irqPending = 1'b1;
    pair(ins(iit_pkg::CLS_IDLE, 5'h02, 1'b0), ins(iit_pkg::CLS_OTHER, 5'h02, 1'b0), '0, 0);
    irqPending = 1'b0;
    pair(ins(iit_pkg::CLS_IDLE, 5'h02, 1'b0), ins(iit_pkg::CLS_OTHER, 5'h02, 1'b0), '0, -1);
    check(32'(n), 32'd60);
    @(negedge mclk);
    offerValid = 1'b1;
    check(idleWait, 1'b1);
    irqPending = 1'b1;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (issue !== 1'b1 && n < 20);
    check(issue, 1'b1);
    offerValid = 1'b0;
    irqPending = 1'b0;
    $display("test idle done");
  endtask
  task t_id;
    @(negedge mclk);
    procIdRead = 1'b1;
    @(negedge mclk);
    procIdRead = 1'b0;
    n = 0;
    while (procIdValid !== 1'b1 && n < 5) begin
      @(negedge mclk);
      n++;
    end
    check(procIdValid, 1'b1);
    check(procIdData, ID);
    @(negedge mclk);
    check(procIdValid, 1'b0);
    $display("test id done");
  endtask
  // clock enable low in mid-stall must freeze the count and the bubble
  task t_freeze;
    offer = ins(iit_pkg::CLS_SYSCP_MOVE_TO, 5'h02, 1'b0);
    offerValid = 1'b1;
    @(negedge mclk);
    check(issue, 1'b1);
    offer = ins(iit_pkg::CLS_OTHER, 5'h02, 1'b0);
    @(negedge mclk);
    check(stallLeft, 32'h2);
    clkEn = 1'b0;
    repeat (5) @(negedge mclk);
    check(stallLeft, 32'h2);
    check(bubble, 1'b1);
    clkEn = 1'b1;
    n = 6;
    do begin
      @(negedge mclk);
      n++;
    end while (issue !== 1'b1 && n < 60);
    check(32'(n), 32'd9);
    offerValid = 1'b0;
    $display("test freeze done");
  endtask
  initial begin
    repeat (10) @(negedge mclk);
    check({issue, bubble, idleWait, procIdValid}, 32'h0);
    check(stallLeft, 32'h0);
    rstn = 1'b1;
    t_plain();
    t_branch();
    t_mdu();
    t_raw();
    t_media();
    t_div();
    t_idle();
    t_id();
    t_freeze();
    stop_test();
  end
endmodule
`default_nettype wire
